// ---- src/pps_regs.sv ----
// register bank for pulse output control, phase compensation and power sign status
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - bit 10 set (reset 1) holds pulse output two inactive; converter keeps running
// - bit 11 set (reset 1) holds pulse output three inactive; converter keeps running
// - bit 12 set captures energy registers on each pulse-one converter pulse
// - bit 13 set captures energy registers on each pulse-two converter pulse
// - bit 14 set captures energy registers on each pulse-three converter pulse
// - config bit 15 has no effect and resets to zero
// - values 384 to 511 act like 256 to 383
// - values 576 to 1023 act like 384 to 511
// - compensation registers reset to zero; bits 15 to 10 reserved
// - sign bits 0..2 show negative selected active power per phase
// - sign bit 3 shows negative sum in pulse datapath one
// - sign bits 4..6 show negative selected reactive power per phase
// - without reactive measurement, reactive sign bits read zero
// - bit 9 set (reset 1) holds pulse output one inactive; converter keeps running
// - sign bit 7 shows negative sum in pulse datapath two
// - sign bit 8 shows negative sum in datapath three; bits 15..9 read zero
module pps_regs
    import pps_pkg::*;
#(
    parameter bit HAS_REACTIVE = 1'b1
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // power datapath
    input  wire pps_phase_pwr_s [2:0]  phase_pwr,
    input  wire logic [8:0]            path_phase_sel,
    input  wire logic                  active_sign_source_sel,
    input  wire logic                  reactive_sign_source_sel,
    input  wire logic [2:0]            conv_pulse,
    // pulse outputs and energy snapshots
    output logic [2:0]                 pulse_out,
    output logic [2:0]                 snapshot_strobe,
    output logic [2:0][9:0]            phase_comp_value,
    // interrupt
    output logic                       irq
);

    // ***************************************************************
    // state
    // ***************************************************************
    pps_state_s st_reg;
    pps_state_s st_next;

    logic [2:0]        path_neg;
    logic [2:0]        act_neg;
    logic [2:0]        rea_neg;
    logic [8:0]        sign_now;
    logic [15:0]       idx;
    logic              setup;
    logic              access;
    logic              wr_ok;
    logic              rd_stat;
    logic              hit;
    logic              ro_hit;
    logic [15:0]       rd_word;
    logic [IRQ_W-1:0]  irq_set;

    // ***************************************************************
    // sign sources
    // ***************************************************************
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            // per-phase sign of the selected active and reactive power
            assign act_neg[p] = active_sign_source_sel ? phase_pwr[p].fund_active[PWR_W-1]
                                                       : phase_pwr[p].total_active[PWR_W-1];
            assign rea_neg[p] = HAS_REACTIVE && (reactive_sign_source_sel
                                ? phase_pwr[p].fund_reactive[PWR_W-1]
                                : phase_pwr[p].total_reactive[PWR_W-1]);
        end
        for (p = 0; p < 3; p++) begin : g_path
            logic [2:0]        src;
            logic signed [25:0] sum;
            // sum of the selected phases for the datapath's power type
            always_comb begin
                sum = '0;
                src = st_reg.cfg[CFG_SEL_LSB + p*CFG_SEL_W +: CFG_SEL_W];
                for (int q = 0; q < 3; q++) begin
                    if (path_phase_sel[p*3 + q]) begin
                        case (src)
                            SRC_TOT_ACT:  sum = sum + 26'(phase_pwr[q].total_active);
                            SRC_TOT_REA:  sum = sum + 26'(phase_pwr[q].total_reactive);
                            SRC_APPARENT: sum = sum + 26'(phase_pwr[q].apparent);
                            SRC_FUN_ACT:  sum = sum + 26'(phase_pwr[q].fund_active);
                            SRC_FUN_REA:  sum = sum + 26'(phase_pwr[q].fund_reactive);
                            default:      sum = sum;
                        endcase
                    end
                end
            end
            assign path_neg[p] = sum[25];
        end
        for (p = 0; p < 3; p++) begin : g_comp
            logic [9:0] v;
            // alias the reserved compensation ranges onto working ones
            always_comb begin
                v = st_reg.comp[p];
                if (v > COMP_LEAD_MAX && v < COMP_LAG_MIN) begin
                    phase_comp_value[p] = v - COMP_ALIAS1;
                end else if (v > COMP_LAG_MAX) begin
                    phase_comp_value[p] = COMP_BASE2 + {3'h0, 7'(v - COMP_LAG_MAX - 10'h001)};
                end else begin
                    phase_comp_value[p] = v;
                end
            end
        end
    endgenerate

    assign sign_now = {path_neg[2], path_neg[1], rea_neg, path_neg[0], act_neg};

    // ***************************************************************
    // apb decode
    // ***************************************************************
    assign idx    = paddr[ADDR_W-1:2];
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign pready = access; // every access completes in one cycle

    // address decoding and read mux
    always_comb begin
        hit     = 1'b1;
        ro_hit  = 1'b0;
        rd_word = 16'h0000;
        if (idx == IDX_CFG) begin
            rd_word = st_reg.cfg;
        end else if (idx == IDX_COMP_A) begin
            rd_word = {6'h00, st_reg.comp[0]};
        end else if (idx == IDX_COMP_B) begin
            rd_word = {6'h00, st_reg.comp[1]};
        end else if (idx == IDX_COMP_C) begin
            rd_word = {6'h00, st_reg.comp[2]};
        end else if (idx == IDX_SIGN) begin
            rd_word = {7'h00, st_reg.sign};
            ro_hit  = 1'b1;
        end else if (idx == IDX_IRQ_STAT) begin
            rd_word = {4'h0, st_reg.irq_stat};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_word = {4'h0, st_reg.irq_mask};
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_ok   = access && pwrite && !st_reg.pslverr;
    assign rd_stat = access && !pwrite && idx == IDX_IRQ_STAT;
    assign irq_set = {st_reg.snap, st_reg.sign ^ sign_now};

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        st_next = st_reg;
        // answer is prepared in the setup cycle and held through access
        if (setup) begin
            st_next.prdata  = {16'h0000, rd_word};
            st_next.pslverr = !hit || (pwrite && ro_hit);
        end
        if (wr_ok) begin
            if (idx == IDX_CFG) begin
                st_next.cfg = lane_merge(st_reg.cfg, pwdata, pstrb);
            end else if (idx == IDX_COMP_A) begin
                st_next.comp[0] = 10'(lane_merge({6'h00, st_reg.comp[0]}, pwdata, pstrb));
            end else if (idx == IDX_COMP_B) begin
                st_next.comp[1] = 10'(lane_merge({6'h00, st_reg.comp[1]}, pwdata, pstrb));
            end else if (idx == IDX_COMP_C) begin
                st_next.comp[2] = 10'(lane_merge({6'h00, st_reg.comp[2]}, pwdata, pstrb));
            end else if (idx == IDX_IRQ_MASK) begin
                st_next.irq_mask = 12'(lane_merge({4'h0, st_reg.irq_mask}, pwdata, pstrb));
            end
        end
        // sign status follows the datapath
        st_next.sign = sign_now;
        // converters keep running; only the pin is gated
        st_next.pulse = conv_pulse & ~st_reg.cfg[CFG_OFF_LSB +: 3];
        st_next.snap  = conv_pulse & st_reg.cfg[CFG_SNAP_LSB +: 3];
        // read clears, a new event in the same cycle wins
        st_next.irq_stat = (st_reg.irq_stat & ~{IRQ_W{rd_stat}}) | irq_set;
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg          <= '0;
            st_reg.cfg      <= CFG_RESET;
        end else begin
            st_reg          <= st_next;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign prdata          = st_reg.prdata;
    assign pslverr         = st_reg.pslverr && access;
    assign pulse_out       = st_reg.pulse;
    assign snapshot_strobe = st_reg.snap;
    assign irq             = |(st_reg.irq_stat & st_reg.irq_mask);

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    pulse_one_gate_a: assert property ((conv_pulse[0] && st_reg.cfg[9]) |=> !pulse_out[0])
        else $error("pulse one driven while disabled");
    pulse_two_gate_a: assert property ((conv_pulse[1] && !st_reg.cfg[10]) |=> pulse_out[1])
        else $error("pulse two missing while enabled");
    pulse_three_gate_a: assert property ((conv_pulse[2] && st_reg.cfg[11]) |=> !pulse_out[2])
        else $error("pulse three driven while disabled");
    snap_one_a: assert property ((conv_pulse[0] && st_reg.cfg[12]) |=> snapshot_strobe[0])
        else $error("snapshot one missed");
    snap_two_a: assert property ((conv_pulse[1] && !st_reg.cfg[13]) |=> !snapshot_strobe[1])
        else $error("snapshot two without enable");
    snap_three_a: assert property (snapshot_strobe[2] |-> $past(conv_pulse[2]))
        else $error("snapshot three without pulse");
    comp_alias_low_a: assert property ((st_reg.comp[0] >= 10'h180 && st_reg.comp[0] <= 10'h1ff)
        |-> phase_comp_value[0] == st_reg.comp[0] - 10'h080)
        else $error("compensation alias 384..511 wrong");
    comp_alias_high_a: assert property ((st_reg.comp[1] >= 10'h240)
        |-> phase_comp_value[1] >= 10'h180 && phase_comp_value[1] <= 10'h1ff)
        else $error("compensation alias 576..1023 wrong");
    comp_read_high_a: assert property ((setup && !pwrite && idx == IDX_COMP_C)
        |=> prdata[15:10] == 6'h00)
        else $error("compensation reserved bits not zero");
    active_sign_a: assert property (##1 st_reg.sign[0] == $past(act_neg[0]))
        else $error("phase a active sign stale");
    sum_one_sign_a: assert property (path_neg[0] |=> st_reg.sign[SIGN_SUM1])
        else $error("path one sum sign missed");
    reactive_sign_a: assert property (!HAS_REACTIVE |-> st_reg.sign[6:4] == 3'h0)
        else $error("reactive sign set without reactive");
    sum_two_sign_a: assert property (!path_neg[1] |=> !st_reg.sign[SIGN_SUM2])
        else $error("path two sum sign wrong");
    sign_read_top_a: assert property ((setup && !pwrite && idx == IDX_SIGN)
        |=> prdata[15:9] == 7'h00 && prdata[8:0] == $past(st_reg.sign))
        else $error("sign register read wrong");
    clear_set_wins_a: assert property ((rd_stat && irq_set[0]) |=> st_reg.irq_stat[0])
        else $error("event lost on read clear");

    // each gate in its other polarity
    pulse_one_pass_a: assert property ((conv_pulse[0] && !st_reg.cfg[9]) |=> pulse_out[0])
        else $error("pulse one missing");

    pulse_two_hold_a: assert property ((conv_pulse[1] && st_reg.cfg[10]) |=> !pulse_out[1])
        else $error("pulse two leaked");

    pulse_three_pass_a: assert property ((conv_pulse[2] && !st_reg.cfg[11]) |=> pulse_out[2])
        else $error("pulse three missing");

    // a quiet converter leaves its pin quiet
    pulse_quiet_a: assert property (!conv_pulse[1] |=> !pulse_out[1])
        else $error("pulse two spurious");

    // snapshot strobes follow their enables only
    snap_one_off_a: assert property ((conv_pulse[0] && !st_reg.cfg[12]) |=> !snapshot_strobe[0])
        else $error("snapshot one unasked");

    snap_two_on_a: assert property ((conv_pulse[1] && st_reg.cfg[13]) |=> snapshot_strobe[1])
        else $error("snapshot two missed");

    snap_three_on_a: assert property ((conv_pulse[2] && st_reg.cfg[14]) |=> snapshot_strobe[2])
        else $error("snapshot three missed");

    // compensation ranges on the other phases
    comp_lead_pass_a: assert property (st_reg.comp[2] <= 10'h17f |-> phase_comp_value[2] == st_reg.comp[2])
        else $error("lead value altered");

    comp_lag_pass_a: assert property ((st_reg.comp[2] >= 10'h200 && st_reg.comp[2] <= 10'h23f)
        |-> phase_comp_value[2] == st_reg.comp[2])
        else $error("lag value altered");

    comp_alias_b_a: assert property ((st_reg.comp[1] >= 10'h180 && st_reg.comp[1] <= 10'h1ff)
        |-> phase_comp_value[1] == st_reg.comp[1] - 10'h080)
        else $error("alias b wrong");

    comp_alias_c_a: assert property ((st_reg.comp[2] >= 10'h240)
        |-> phase_comp_value[2] == 10'h180 + {3'h0, st_reg.comp[2][6:0] - 7'h40})
        else $error("alias c wrong");

    comp_alias_a_high_a: assert property ((st_reg.comp[0] >= 10'h240)
        |-> phase_comp_value[0] == 10'h180 + {3'h0, st_reg.comp[0][6:0] - 7'h40})
        else $error("alias a wrong");

    // a full write lands in the low ten bits
    comp_write_a: assert property ((wr_ok && idx == IDX_COMP_A && pstrb[1:0] == 2'h3)
        |=> st_reg.comp[0] == $past(pwdata[9:0]))
        else $error("compensation write lost");

    // ***************************************************************
    // sign status, bus answer and interrupt
    // ***************************************************************
    // each sign bit is the datapath sign of the cycle before
    active_sign_b_a: assert property (##1 st_reg.sign[1] == $past(act_neg[1]))
        else $error("phase b sign stale");

    active_sign_c_a: assert property (##1 st_reg.sign[2] == $past(act_neg[2]))
        else $error("phase c sign stale");

    reactive_pass_a: assert property (##1 st_reg.sign[6:4] == $past(rea_neg))
        else $error("reactive sign stale");

    sum_one_clear_a: assert property (!path_neg[0] |=> !st_reg.sign[SIGN_SUM1])
        else $error("path one sign stuck");

    sum_two_set_a: assert property (path_neg[1] |=> st_reg.sign[SIGN_SUM2])
        else $error("path two sign missed");

    sum_three_sign_a: assert property (path_neg[2] |=> st_reg.sign[8])
        else $error("path three sign missed");

    sum_three_clear_a: assert property (!path_neg[2] |=> !st_reg.sign[8])
        else $error("path three sign stuck");

    // zero wait states, errors only in access
    zero_wait_a: assert property (access |-> pready)
        else $error("access stalled");

    pready_idle_a: assert property (!psel |-> !pready)
        else $error("ready while idle");

    pslverr_quiet_a: assert property (!access |-> !pslverr)
        else $error("error outside access");

    unmapped_err_a: assert property ((setup && !hit) |=> pslverr)
        else $error("unmapped access accepted");

    sign_write_err_a: assert property ((setup && pwrite && idx == IDX_SIGN) |=> pslverr)
        else $error("sign write accepted");

    prdata_top_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read half set");

    // interrupt follows status and mask
    irq_clear_a: assert property ((rd_stat && irq_set == '0) |=> !irq)
        else $error("interrupt kept after clear");

    irq_pending_a: assert property ((irq_set[9] && st_reg.irq_mask[9]) |=> irq)
        else $error("snapshot interrupt missed");

    pulse_seen_c: cover property (pulse_out[0] ##1 snapshot_strobe[1]);
    irq_raise_c: cover property (!irq ##1 irq);
    read_clear_c: cover property (rd_stat ##1 !irq);
    bad_addr_c: cover property (access && pslverr);
    comp_alias_c: cover property (st_reg.comp[0] > 10'h23f);

endmodule

`default_nettype wire

// ---- src/pps_pkg.sv ----
// constants and carrier types shared by the pulse, phase-compensation and sign register bank
package pps_pkg;

    // ***************************************************************
    // register indices; byte address on apb is four times the index
    // ***************************************************************
    localparam logic [15:0] IDX_CFG       = 16'he610;
    localparam logic [15:0] IDX_COMP_A    = 16'he614;
    localparam logic [15:0] IDX_COMP_B    = 16'he615;
    localparam logic [15:0] IDX_COMP_C    = 16'he616;
    localparam logic [15:0] IDX_SIGN      = 16'he617;
    localparam logic [15:0] IDX_IRQ_STAT  = 16'he618;
    localparam logic [15:0] IDX_IRQ_MASK  = 16'he619;
    localparam int          ADDR_W        = 18;

    // ***************************************************************
    // field positions and reset values
    // ***************************************************************
    localparam logic [15:0] CFG_RESET     = 16'h0e88;
    localparam int          CFG_SEL_LSB   = 0;
    localparam int          CFG_SEL_W     = 3;
    localparam int          CFG_OFF_LSB   = 9;
    localparam int          CFG_SNAP_LSB  = 12;
    localparam int          COMP_W        = 10;
    localparam int          SIGN_W        = 9;
    localparam int          SIGN_ACT_LSB  = 0;
    localparam int          SIGN_SUM1     = 3;
    localparam int          SIGN_REA_LSB  = 4;
    localparam int          SIGN_SUM2     = 7;
    localparam int          IRQ_W         = 12;
    localparam int          IRQ_SNAP_LSB  = 9;

    // ***************************************************************
    // phase-compensation alias ranges
    // ***************************************************************
    localparam logic [9:0]  COMP_LEAD_MAX = 10'h17f;
    localparam logic [9:0]  COMP_LAG_MIN  = 10'h200;
    localparam logic [9:0]  COMP_LAG_MAX  = 10'h23f;
    localparam logic [9:0]  COMP_ALIAS1   = 10'h080;
    localparam logic [9:0]  COMP_BASE2    = 10'h180;

    // ***************************************************************
    // power source select codes and carriers
    // ***************************************************************
    localparam logic [2:0]  SRC_TOT_ACT   = 3'h0;
    localparam logic [2:0]  SRC_TOT_REA   = 3'h1;
    localparam logic [2:0]  SRC_APPARENT  = 3'h2;
    localparam logic [2:0]  SRC_FUN_ACT   = 3'h3;
    localparam logic [2:0]  SRC_FUN_REA   = 3'h4;
    localparam int          PWR_W         = 24;

    typedef struct packed {
        logic signed [23:0] total_active;
        logic signed [23:0] total_reactive;
        logic signed [23:0] apparent;
        logic signed [23:0] fund_active;
        logic signed [23:0] fund_reactive;
    } pps_phase_pwr_s;

    typedef struct packed {
        logic [15:0]       cfg;
        logic [2:0][9:0]   comp;
        logic [8:0]        sign;
        logic [11:0]       irq_stat;
        logic [11:0]       irq_mask;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [2:0]        pulse;
        logic [2:0]        snap;
    } pps_state_s;

endpackage

// ---- verification/pps_regs_bench.sv ----
// self-checking bench for the pulse, phase-compensation and sign register bank
`timescale 1ns/1ps
`default_nettype none
module pps_regs_bench
    import pps_pkg::*;
;
    logic                  clk, reset, psel, penable, pwrite, pready, pslverr, asel, rsel, irq;
    logic [ADDR_W-1:0]     paddr;
    logic [31:0]           pwdata, prdata, rd, prdata_nr;
    logic [3:0]            pstrb;
    pps_phase_pwr_s [2:0]  phase_pwr;
    logic [8:0]            path_sel;
    logic [2:0]            conv, pulse_out, snap, prev;
    logic [2:0][9:0]       comp_val;
    logic [15:0]           cfg;
    logic [9:0]            v;
    int                    err_count, n_compared, cycles;
    logic [9:0]            corner [8] = '{10'd0, 10'd383, 10'd384, 10'd511, 10'd512, 10'd575, 10'd576, 10'd1023};

    pps_regs dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phase_pwr(phase_pwr), .path_phase_sel(path_sel), .active_sign_source_sel(asel),
        .reactive_sign_source_sel(rsel), .conv_pulse(conv), .pulse_out(pulse_out),
        .snapshot_strobe(snap), .phase_comp_value(comp_val), .irq(irq));

    // variant without reactive measurement, sharing every input
    pps_regs #(.HAS_REACTIVE(1'b0)) dut_nr (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(prdata_nr),
        .pslverr(), .phase_pwr(phase_pwr), .path_phase_sel(path_sel), .active_sign_source_sel(asel),
        .reactive_sign_source_sel(rsel), .conv_pulse(conv), .pulse_out(), .snapshot_strobe(),
        .phase_comp_value(), .irq());

    // ***************************************************************
    // clock, timeout and helpers
    // ***************************************************************
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] data,
                       output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        pstrb   <= 4'h3;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        data = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [15:0] idx, input logic [31:0] wd, input logic exp_err);
        logic e;
        apb(1'b1, idx, wd, rd, e);
        chk(e, exp_err);
        if (idx == IDX_CFG) cfg = wd[15:0];
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
        logic e;
        apb(1'b0, idx, 32'h0, rd, e);
        chk(e, exp_err);
        if (!exp_err) chk(rd, exp);
    endtask

    function automatic logic [9:0] alias_of(input logic [9:0] x);
        if (x < 10'd384 || (x >= 10'd512 && x < 10'd576)) return x;
        if (x < 10'd512) return x - 10'd128;
        return 10'd384 + ((x - 10'd576) % 10'd128);
    endfunction

    function automatic logic [8:0] exp_sign(input pps_phase_pwr_s [2:0] pw, input logic [8:0] ps, input logic a,
                                            input logic r, input logic [15:0] c);
        logic [8:0] s;
        logic signed [27:0] sum;
        logic signed [23:0] f;
        s = '0;
        for (int q = 0; q < 3; q++) begin
            s[q]   = a ? pw[q].fund_active[23] : pw[q].total_active[23];
            s[4+q] = r ? pw[q].fund_reactive[23] : pw[q].total_reactive[23];
        end
        for (int p = 0; p < 3; p++) begin
            sum = '0;
            for (int q = 0; q < 3; q++) begin
                case (c[3*p+:3])
                    3'h0: f = pw[q].total_active;
                    3'h1: f = pw[q].total_reactive;
                    3'h2: f = pw[q].apparent;
                    3'h3: f = pw[q].fund_active;
                    3'h4: f = pw[q].fund_reactive;
                    default: f = '0;
                endcase
                if (ps[3*p+q]) sum = sum + f;
            end
            s[(p == 0) ? 3 : 6 + p] = (sum < 0);
        end
        return s;
    endfunction

    function automatic logic signed [23:0] rnd24();
        return 24'($urandom_range(0, 4194303)) - 24'h200000;
    endfunction

    // ***************************************************************
    // main sequence
    // ***************************************************************
    // reset, then one test after another
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, asel, rsel, conv, path_sel} = '0;
        phase_pwr = '0;
        prev = '0;
        reset = 1'b1;
        void'($urandom(32'h60e86e54));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd_chk(IDX_CFG, 32'h0e88, 1'b0);
        cfg = 16'h0e88;
        for (int p = 0; p < 3; p++) rd_chk(IDX_COMP_A + 16'(p), 32'h0, 1'b0);
        rd_chk(IDX_SIGN, 32'h0, 1'b0);
        rd_chk(IDX_IRQ_MASK, 32'h0, 1'b0);
        rd_chk(16'h0000, 32'h0, 1'b1);
        wr_reg(IDX_SIGN, 32'h1ff, 1'b1);
        wr_reg(IDX_CFG, 32'h8e88, 1'b0);
        rd_chk(IDX_CFG, 32'h8e88, 1'b0);
        $display("test reset_and_access done");
        // pulse gating and snapshot strobes, back to back
        for (int i = 0; i < 40; i++) begin
            wr_reg(IDX_CFG, (i == 0) ? 32'h8000 : 32'h7e00 & $urandom, 1'b0);
            for (int k = 0; k < 10; k++) begin
                @(posedge clk);
                conv <= (k < 9) ? 3'($urandom) : 3'h0;
                #1;
                chk(pulse_out, prev & ~cfg[11:9]);
                chk(snap, prev & cfg[14:12]);
                prev = (k < 9) ? conv : 3'h0;
            end
        end
        $display("test pulses done");
        // compensation aliasing, corners then random
        for (int i = 0; i < 30; i++) begin
            v = (i < 8) ? corner[i] : 10'($urandom);
            wr_reg(IDX_COMP_A + 16'(i % 3), {16'h0, 6'($urandom), v}, 1'b0);
            rd_chk(IDX_COMP_A + 16'(i % 3), {22'h0, v}, 1'b0);
            chk(comp_val[i % 3], alias_of(v));
        end
        $display("test compensation done");
        // sign status over random powers and selections
        for (int i = 0; i < 30; i++) begin
            if (i % 5 == 1) wr_reg(IDX_CFG, $urandom & 32'hffff, 1'b0);
            @(posedge clk);
            for (int q = 0; q < 3; q++)
                phase_pwr[q] <= (i == 0) ? '0 : {rnd24(), rnd24(), rnd24(), rnd24(), rnd24()};
            path_sel <= (i == 0) ? 9'h1ff : 9'($urandom);
            asel     <= 1'($urandom);
            rsel     <= 1'($urandom);
            repeat (3) @(posedge clk);
            rd_chk(IDX_SIGN, {23'h0, exp_sign(phase_pwr, path_sel, asel, rsel, cfg)}, 1'b0);
            chk(prdata_nr, {23'h0, exp_sign(phase_pwr, path_sel, asel, rsel, cfg) & 9'h18f});
        end
        $display("test sign done");
        // snapshot interrupt: raise, clear by read, mask
        wr_reg(IDX_CFG, 32'h1000, 1'b0);
        wr_reg(IDX_IRQ_MASK, 32'h200, 1'b0);
        repeat (3) @(posedge clk);
        apb(1'b0, IDX_IRQ_STAT, 32'h0, rd, v[0]);
        @(posedge clk);
        #1 chk(irq, 1'b0);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            conv <= 3'h1;
            @(posedge clk);
            conv <= 3'h0;
            repeat (3) @(posedge clk);
            #1 chk(irq, (m == 0));
            rd_chk(IDX_IRQ_STAT, 32'h200, 1'b0);
            rd_chk(IDX_IRQ_STAT, 32'h0, 1'b0);
            #1 chk(irq, 1'b0);
            wr_reg(IDX_IRQ_MASK, 32'h0, 1'b0);
        end
        $display("test interrupt done");
        complete_run();
    end
endmodule
`default_nettype wire
